/* bench/emcfg_mem.sv */
// Purpose: external address latch plus byte memory, async read and clocked write
// Assumes: memory drives ad only under the read strobe
// Notes: 256 bytes, indexed by low address only
`timescale 1ns/1ps
module emcfg_mem (
  // pins from the device
  input wire mclk,
  input wire [7:0] ad_out,
  input wire [7:0] alo_out,
  input wire ad_oe,
  input wire alo_oe,
  input wire ale,
  input wire rd_n,
  input wire wr_n,
  // pins back to the device
  output wire [7:0] ad_in
);
  reg [7:0] q;
  reg [7:0] mem [0:255];
  wire [7:0] a = alo_oe ? alo_out : q;
  // transparent while ale high, frozen after it falls
  always @(ale or ad_out) if (ale) q <= ad_out;
  // write strobe takes data from the shared pins
  always @(posedge mclk) if (!wr_n) mem[a] <= ad_out;
  // device drive wins; memory under read strobe; a floating bus inverts
  assign ad_in = ad_oe ? ad_out : (!rd_n ? mem[a] : ~ad_out);
endmodule

/* bench/emcfg_monitor.sv */
// Purpose: port level checks of the configuration and bus sequencer
// Assumes: move inputs held steady until mv_done
// Notes: keeps a shadow of the config register from writes
`timescale 1ns/1ps
module emcfg_monitor (
  // clock, reset and pins watched
  input wire mclk,
  input wire arst_n,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire mv_req,
  input wire [15:0] mv_addr,
  input wire mv_bank,
  input wire [7:0] mv_wdata,
  input wire mv_busy,
  input wire mv_done,
  input wire fifo_req,
  input wire [9:0] fifo_addr,
  input wire [7:0] ad_out,
  input wire ad_oe,
  input wire [7:0] alo_out,
  input wire alo_oe,
  input wire [7:0] ahi_out,
  input wire ahi_oe,
  input wire ale,
  input wire rd_n,
  input wire wr_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  reg [7:0] cfg_s;
  reg [2:0] cnt;
  wire hit = cfg_s[6] && mv_addr[15:10] == 6'h01;
  wire go = mv_req && !mv_busy;
  // shadow config and ale high-time counter
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_s <= 8'h03;
      cnt <= 3'h0;
    end else begin
      if (sfr_wr && sfr_addr == 8'h85) cfg_s <= sfr_wdata & 8'h5f;
      cnt <= ale ? cnt + 3'h1 : 3'h0;
    end
  end
  sequence s_turn;
    !ad_oe && rd_n && wr_n;
  endsequence
  sequence s_strobe;
    (rd_n != wr_n) [*3];
  endsequence
  a_cfg_readback: assert property (
    sfr_rdata == (sfr_addr == 8'h85 ? cfg_s : 8'h00))
    else $error("config readback wrong");
  a_ale_mux_only: assert property (ale |-> !cfg_s[4])
    else $error("ale in separate pin mode");
  a_ale_width: assert property (
    $fell(ale) |-> cnt == {1'b0, cfg_s[1:0]} + 3'h1)
    else $error("ale high time wrong");
  a_phase_one: assert property (
    ale |-> ad_oe && ad_out == mv_addr[7:0] && rd_n && wr_n)
    else $error("low address not on shared pins");
  a_phase_two: assert property (
    $fell(ale) |-> s_turn ##1 s_strobe ##1 (rd_n && wr_n && mv_done))
    else $error("second phase sequence wrong");
  a_write_data: assert property (!wr_n |-> ad_oe && ad_out == mv_wdata)
    else $error("write data not on pins");
  a_high_addr: assert property (
    ale || !rd_n || !wr_n |-> ahi_out == mv_addr[15:8] &&
    ahi_oe == (!mv_bank || cfg_s[3:2] == 2'h2))
    else $error("high address pins wrong");
  a_sep_pins: assert property (
    !wr_n && cfg_s[4] |-> alo_oe && alo_out == mv_addr[7:0] && !ale)
    else $error("separate address pins wrong");
  a_fifo_map: assert property (
    go && hit |=> fifo_req && fifo_addr == mv_addr[9:0] && rd_n ##1 mv_done)
    else $error("fifo access wrong");
  a_onchip_quiet: assert property (
    go && cfg_s[3:2] == 2'h0 && !hit |=>
    (rd_n && wr_n && !ale) throughout (##[0:3] mv_done))
    else $error("on-chip access touched pins");
endmodule

/* bench/emcfg_top_tb.sv */
// Purpose: directed bench for the configuration and bus sequencer
// Assumes: inputs change at the falling edge only
// Notes: separate pin writes are read back in both bus modes
`timescale 1ns/1ps
`include "emcfg_regs.vh"
module emcfg_top_tb;
  reg mclk = 1'b0;
  reg arst_n = 1'b0;
  reg sfr_wr = 1'b0, mv_req = 1'b0, mv_write = 1'b0, mv_bank = 1'b0;
  reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, mv_wdata = 8'h00;
  reg [7:0] fifo_rdata = 8'h3c;
  reg [15:0] mv_addr = 16'h0000;
  wire [7:0] sfr_rdata, mv_rdata, fifo_wdata, ad_out, ad_in;
  wire [7:0] ahi_out, alo_out;
  wire [9:0] fifo_addr;
  wire mv_busy, mv_done, fifo_req, fifo_write, ad_oe, ahi_oe, alo_oe;
  wire ale, rd_n, wr_n;
  integer fails = 0, tests_run = 0, i, n;
  reg [7:0] r;
  emcfg_top dut_u (.*);
  emcfg_mem mem_u (.*);
  always #4 mclk = ~mclk;
  task end_sim;
    begin
      if (fails == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] d);
    begin
      sfr_addr = `EMCFG_CFG_ADDR;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge mclk);
      sfr_wr = 1'b0;
    end
  endtask
  // one move; waits for mv_done under a bounded count
  task mv(input w, input [15:0] a, input [7:0] d);
    begin
      mv_write = w;
      mv_addr = a;
      mv_wdata = d;
      mv_req = 1'b1;
      @(negedge mclk);
      mv_req = 1'b0;
      n = 0;
      while (mv_done !== 1'b1 && n < 40) begin
        @(negedge mclk);
        n = n + 1;
      end
      if (n == 40) fails = fails + 1;
      r = mv_rdata;
    end
  endtask
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #16000;
    fails = fails + 1;
    end_sim;
  end
  initial begin
    repeat (5) @(negedge mclk);
    arst_n = 1'b1;
    sfr_addr = 8'h84;
    #1 chk(sfr_rdata, 8'h00);
    sfr_addr = `EMCFG_CFG_ADDR;
    #1 chk(sfr_rdata, `EMCFG_CFG_RESET);
    @(negedge mclk);
    wr(8'hff);
    chk(sfr_rdata, `EMCFG_CFG_MASK);
    // muxed off-chip at every ale width
    for (i = 0; i < 4; i = i + 1) begin
      wr({6'h03, i[1:0]});
      mv(1'b1, {14'h0440, i[1:0]}, {6'h28, i[1:0]});
      mv(1'b0, {14'h0440, i[1:0]}, 8'h00);
      chk(r, {6'h28, i[1:0]});
    end
    wr(8'h1c);
    mv(1'b1, 16'h2233, 8'h5c);
    chk(ahi_out, 8'h22);
    mv(1'b0, 16'h2233, 8'h00);
    chk(r, 8'h5c);
    wr(8'h0c);
    mv(1'b0, 16'h2233, 8'h00);
    chk(r, 8'h5c);
    // page moves: high pins driven only with bank select
    mv_bank = 1'b1;
    mv(1'b0, 16'h2233, 8'h00);
    chk(r, 8'h5c);
    wr(8'h08);
    mv(1'b0, 16'h2233, 8'h00);
    chk(r, 8'h5c);
    mv_bank = 1'b0;
    // on-chip wrap, then both split modes hit on-chip below 0x1000
    wr(8'h00);
    mv(1'b1, 16'h0012, 8'h77);
    for (i = 0; i < 3; i = i + 1) begin
      wr({4'h0, i[1:0], 2'h0});
      mv(1'b0, i == 0 ? 16'h1012 : 16'h0012, 8'h00);
      chk(r, 8'h77);
    end
    // wrapped on-chip address inside the fifo window stays on-chip
    wr(8'h40);
    mv(1'b1, 16'h1412, 8'h69);
    mv(1'b0, 16'h1412, 8'h00);
    chk(r, 8'h69);
    wr(8'h4c);
    mv(1'b0, 16'h0500, 8'h00);
    chk(r, fifo_rdata);
    mv(1'b1, 16'h0456, 8'hc3);
    chk({7'h00, fifo_write}, 8'h01);
    chk(fifo_wdata, 8'hc3);
    chk(fifo_addr[7:0], 8'h56);
    end_sim;
  end
endmodule
bind emcfg_top emcfg_monitor mon_u (
  .mclk(mclk),
  .arst_n(arst_n),
  .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata),
  .mv_req(mv_req),
  .mv_addr(mv_addr),
  .mv_bank(mv_bank),
  .mv_wdata(mv_wdata),
  .mv_busy(mv_busy),
  .mv_done(mv_done),
  .fifo_req(fifo_req),
  .fifo_addr(fifo_addr),
  .ad_out(ad_out),
  .ad_oe(ad_oe),
  .alo_out(alo_out),
  .alo_oe(alo_oe),
  .ahi_out(ahi_out),
  .ahi_oe(ahi_oe),
  .ale(ale),
  .rd_n(rd_n),
  .wr_n(wr_n)
);

/* rtl/emcfg_regs.vh */
// Purpose: constants for the external memory configuration block
// Assumes: 8-bit special register bus, byte addresses as printed
// Notes: timing counts are in system clock periods
`ifndef EMCFG_REGS_VH
`define EMCFG_REGS_VH
`define EMCFG_CFG_ADDR 8'h85
`define EMCFG_CFG_RESET 8'h03
`define EMCFG_CFG_MASK 8'h5f
`define EMCFG_FAE_BIT 6
`define EMCFG_NONMUX_BIT 4
`define EMCFG_MODE_HI 3
`define EMCFG_MODE_LO 2
`define EMCFG_ALE_HI 1
`define EMCFG_ALE_LO 0
`define EMCFG_MODE_ONCHIP 2'h0
`define EMCFG_MODE_SPLIT 2'h1
`define EMCFG_MODE_BANK 2'h2
`define EMCFG_MODE_OFFCHIP 2'h3
`define EMCFG_FIFO_LO 16'h0400
`define EMCFG_FIFO_HI 16'h07ff
`define EMCFG_ONCHIP_MASK 16'h0fff
`define EMCFG_ONCHIP_SIZE 16'h1000
// strobe stays low count plus one periods; the read sampler needs three
`define EMCFG_STROBE_CYC 2'h2
`endif

/* rtl/emcfg_top.v */
// Overview of operation
// - bits 7 and 5 of config read zero, writes to them ignored
// - bit 6 enables direct move access to the usb fifo memory
// - bit 4 zero selects multiplexed bus, one selects separate pins
// - multiplexed: data and low address byte share the eight ad pins
// - multiplexed: this logic drives the address latch enable output
// - first phase: latch enable high, low address on shared pins
// - latch enable falling starts phase two; external latch holds
// - later in phase two shared pins carry data during the strobe
// - non-multiplexed: address and data on dedicated separate pins
// - mode field picks on-chip, split, split with bank, off-chip
// - fifo enable maps fifo at 0x0400..0x07ff, hiding normal memory
// Purpose: external memory interface configuration and bus sequencer
// Assumes: cpu core presents one move request as a one-cycle pulse
// Notes: fifo port is a simple one-cycle handshake to the usb side
`timescale 1ns/1ps
`include "emcfg_regs.vh"
module emcfg_top (
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // special register bus
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  output wire [7:0] sfr_rdata,
  // external data move request from the core
  input wire mv_req,
  input wire mv_write,
  input wire [15:0] mv_addr,
  input wire mv_bank,
  input wire [7:0] mv_wdata,
  output wire mv_busy,
  output reg mv_done,
  output reg [7:0] mv_rdata,
  // usb fifo memory port
  output reg fifo_req,
  output reg fifo_write,
  output reg [9:0] fifo_addr,
  output reg [7:0] fifo_wdata,
  input wire [7:0] fifo_rdata,
  // external memory pins
  output reg [7:0] ad_out,
  output reg ad_oe,
  input wire [7:0] ad_in,
  output reg [7:0] ahi_out,
  output reg ahi_oe,
  output reg [7:0] alo_out,
  output reg alo_oe,
  output reg ale,
  output reg rd_n,
  output reg wr_n
);
  localparam S_IDLE = 6'h01;
  localparam S_ALE = 6'h02;
  localparam S_HOLD = 6'h04;
  localparam S_STRB = 6'h08;
  localparam S_INT = 6'h10;
  localparam S_DONE = 6'h20;

  reg [7:0] cfg;
  reg [5:0] state;
  reg [1:0] cnt;
  reg is_wr;
  reg [15:0] addr_q;
  reg [7:0] wdata_q;
  reg is_fifo;
  reg [7:0] ad_s1;
  reg [7:0] ad_s2;
  wire fae;
  wire nonmux;
  wire [1:0] mode;
  wire [1:0] ale_w;
  wire int_wr;
  wire [7:0] int_rdata;

  assign fae = cfg[`EMCFG_FAE_BIT];
  assign nonmux = cfg[`EMCFG_NONMUX_BIT];
  assign mode = cfg[`EMCFG_MODE_HI:`EMCFG_MODE_LO];
  assign ale_w = cfg[`EMCFG_ALE_HI:`EMCFG_ALE_LO];
  assign sfr_rdata = (sfr_addr == `EMCFG_CFG_ADDR) ? cfg : 8'h00;
  assign mv_busy = (state != S_IDLE);

  // fifo window decode at request time
  function in_fifo;
    input [15:0] a;
    input en;
    begin
      in_fifo = en && (a >= `EMCFG_FIFO_LO) && (a <= `EMCFG_FIFO_HI);
    end
  endfunction

  // on-chip or off-chip decision by memory mode
  function off_chip;
    input [15:0] a;
    input [1:0] m;
    begin
      case (m)
        `EMCFG_MODE_ONCHIP: off_chip = 1'b0;
        `EMCFG_MODE_OFFCHIP: off_chip = 1'b1;
        default: off_chip = (a >= `EMCFG_ONCHIP_SIZE);
      endcase
    end
  endfunction

  // high address pins: 16-bit moves always, page moves only in bank mode
  function hi_drive;
    input bank;
    input [1:0] m;
    begin
      hi_drive = !bank || (m == `EMCFG_MODE_BANK);
    end
  endfunction

  // configuration register, unused bits masked off
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= `EMCFG_CFG_RESET;
    end else if (sfr_wr && sfr_addr == `EMCFG_CFG_ADDR) begin
      cfg <= sfr_wdata & `EMCFG_CFG_MASK;
    end
  end

  // pins come from outside, so two flops before use
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ad_s1 <= 8'h00;
      ad_s2 <= 8'h00;
    end else begin
      ad_s1 <= ad_in;
      ad_s2 <= ad_s1;
    end
  end

  assign int_wr = (state == S_INT) && is_wr;

  emcfg_xram u_xram (
    .mclk(mclk),
    .arst_n(arst_n),
    .addr(addr_q[11:0]),
    .wr_en(int_wr),
    .wdata(wdata_q),
    .rdata(int_rdata)
  );

  // access sequencer and pin drivers
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      cnt <= 2'h0;
      is_wr <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      is_fifo <= 1'b0;
      mv_done <= 1'b0;
      mv_rdata <= 8'h00;
      fifo_req <= 1'b0;
      fifo_write <= 1'b0;
      fifo_addr <= 10'h000;
      fifo_wdata <= 8'h00;
      ad_out <= 8'h00;
      ad_oe <= 1'b0;
      ahi_out <= 8'h00;
      ahi_oe <= 1'b0;
      alo_out <= 8'h00;
      alo_oe <= 1'b0;
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
    end else begin
      mv_done <= 1'b0;
      fifo_req <= 1'b0;
      case (state)
        S_IDLE: begin
          if (mv_req) begin
            is_wr <= mv_write;
            addr_q <= mv_addr;
            wdata_q <= mv_wdata;
            // masked on-chip addresses cannot alias into the fifo window
            is_fifo <= in_fifo(mv_addr, fae);
            if (in_fifo(mv_addr, fae)) begin
              fifo_req <= 1'b1;
              fifo_write <= mv_write;
              fifo_addr <= mv_addr[9:0];
              fifo_wdata <= mv_wdata;
              state <= S_DONE;
            end else if (!off_chip(mv_addr, mode)) begin
              // on-chip wraps on the populated size
              addr_q <= mv_addr & `EMCFG_ONCHIP_MASK;
              state <= S_INT;
            end else if (!nonmux) begin
              ale <= 1'b1;
              ad_out <= mv_addr[7:0];
              ad_oe <= 1'b1;
              ahi_out <= mv_addr[15:8];
              ahi_oe <= hi_drive(mv_bank, mode);
              cnt <= ale_w;
              state <= S_ALE;
            end else begin
              // address set up one period ahead of the strobe
              alo_out <= mv_addr[7:0];
              alo_oe <= 1'b1;
              ahi_out <= mv_addr[15:8];
              ahi_oe <= hi_drive(mv_bank, mode);
              state <= S_HOLD;
            end
          end
        end
        S_ALE: begin
          // width field plus one periods of latch enable high
          if (cnt == 2'h0) begin
            ale <= 1'b0;
            ad_oe <= 1'b0;
            state <= S_HOLD;
          end else begin
            cnt <= cnt - 2'h1;
          end
        end
        S_HOLD: begin
          // muxed: latch holds low address; both modes: data and strobe
          ad_out <= wdata_q;
          ad_oe <= is_wr;
          rd_n <= is_wr;
          wr_n <= !is_wr;
          cnt <= `EMCFG_STROBE_CYC;
          state <= S_STRB;
        end
        S_STRB: begin
          if (cnt == 2'h0) begin
            mv_rdata <= ad_s2; // sampled inside the strobe
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            ad_oe <= 1'b0;
            alo_oe <= 1'b0;
            ahi_oe <= 1'b0;
            mv_done <= 1'b1;
            state <= S_IDLE;
          end else begin
            cnt <= cnt - 2'h1;
          end
        end
        S_INT: begin
          state <= S_DONE;
        end
        S_DONE: begin
          mv_rdata <= is_fifo ? fifo_rdata : int_rdata;
          mv_done <= 1'b1;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule

/* rtl/emcfg_xram.v */
// Purpose: small on-chip data memory with registered read data
// Assumes: single clock, one access per cycle
// Notes: no reset on the array, read data resets to zero
`timescale 1ns/1ps
module emcfg_xram (
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // access port
  input wire [11:0] addr,
  input wire wr_en,
  input wire [7:0] wdata,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:4095];

  // read before write, read data registered for timing
  always @(posedge mclk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[addr];
    end
  end
endmodule
